// ===== rtl/asist_pkg.sv
// constants, job codes and state codes of the string transfer job engine
// Contract
// R1 - identification read targets addressed profile-7.4 slave
// R2 - identification read returns at most 220 bytes
// R3 - delivered identification count goes in byte 2
// R4 - overlong string aborts, errors, withholds all bytes
// R5 - identification transfer suspends analog exchange with slave
// R6 - follows/valid bytes passed only for identification
// R7 - record: two zero version bytes, count, strings
// R8 - host sends at most 220 request bytes, address
// R9 - byte 2 count decides bytes forwarded to slave
// R10 - slave response kept for later fetch job
// R11 - string byte 1 onward passed uninterpreted
// R12 - transaction transfer suspends analog, digital keeps running
// R13 - host waits up to thirty seconds
// R14 - response fetch returns reply to write job
// R15 - response record at most 223 bytes, count byte 2
// R16 - only latest response kept, older ones lost
// R17 - write count above 220 rejected, nothing sent
package asist_pkg;

  // ==========================================================
  // record layout
  localparam logic [7:0] STR_MAX  = 8'hdc;  // 220 string bytes at most
  localparam logic [7:0] CNT_POS  = 8'h02;  // byte index of the string count
  localparam logic [7:0] HDR_LEN  = 8'h03;  // bytes ahead of string byte 1
  localparam logic [7:0] VER_HI   = 8'h00;  // format_version_high value
  localparam logic [7:0] VER_LO   = 8'h00;  // format_version_low value
  localparam logic [7:0] CNT_RST  = 8'h00;  // counts after reset

  // ==========================================================
  // job codes; JOB_WR_REQ is the write_transaction_request_job (index 001f)
  typedef enum logic [1:0] {
    JOB_ID_READ = 2'h0,  // identification string read
    JOB_WR_REQ  = 2'h1,  // write_transaction_request_job
    JOB_RD_RESP = 2'h2   // read_transaction_response_job
  } asist_job_t;

  // ==========================================================
  // engine states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,  // waiting for a job
    S_LOAD = 6'h02,  // taking the send record from the host
    S_SEND = 6'h04,  // forwarding request bytes to the slave
    S_RESP = 6'h08,  // collecting the transaction response
    S_IDRX = 6'h10,  // collecting the identification string
    S_OUT  = 6'h20   // streaming a record back to the host
  } asist_state_t;

endpackage

// ===== rtl/asist_cnt.sv
// byte counter with synchronous clear
`timescale 1ns/1ps
module asist_cnt #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         clr,      // clear wins over count
  input  wire logic         inc,      // count one up
  // value
  output logic [W-1:0]      cnt_q
);

  // ==========================================================
  // counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (inc) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // asist_cnt

// ===== rtl/asist_mem.sv
// string byte store with registered read data
`timescale 1ns/1ps
module asist_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port, one cycle latency
  input  wire logic [AW-1:0] raddr,
  output logic [DW-1:0]      rdata_q
);

  // storage is not reset: unread slots are don't-care
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // write
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // ==========================================================
  // read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

endmodule // asist_mem

// ===== rtl/asist_engine.sv
// string transfer job engine between host records and the slave link
`timescale 1ns/1ps
module asist_engine (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // host job request
  input  wire logic        job_start,
  input  wire logic [1:0]  job_kind,
  input  wire logic [4:0]  job_slave,
  // host send record stream
  input  wire logic [7:0]  wr_byte,
  input  wire logic        wr_valid,
  // host job answer and record stream
  output logic             busy_q,
  output logic             job_done_q,
  output logic             job_err_q,
  output logic [7:0]       rd_byte_q,
  output logic             rd_valid_q,
  output logic             rd_last_q,
  // link request
  output logic             lk_start_q,
  output logic             lk_id_q,
  output logic [4:0]       lk_slave_q,
  output logic             lk_abort_q,
  // link transmit bytes
  output logic [7:0]       lk_tx_byte_q,
  output logic             lk_tx_valid_q,
  output logic             lk_tx_last_q,
  input  wire logic        lk_tx_ready,
  // link receive bytes
  input  wire logic [7:0]  lk_rx_byte,
  input  wire logic        lk_rx_valid,
  input  wire logic        lk_rx_fv,
  input  wire logic        lk_rx_end,
  // cyclic exchange control
  output logic             ana_hold_q,
  output logic [4:0]       hold_slave_q
);

  asist_pkg::asist_state_t st_q;       // engine state
  asist_pkg::asist_job_t   kind_q;     // job being served
  logic [7:0]              cnt_q;      // string count of the working record
  logic [7:0]              resp_cnt_q; // count of the kept response
  logic                    tx_ph_q;    // read of next transmit byte issued
  logic [7:0]              idx;        // host-side byte index
  logic [7:0]              lcnt;       // link-side byte count
  logic [7:0]              stg_rd;     // staging store read data
  logic [7:0]              rsp_rd;     // response store read data
  logic [7:0]              ocnt;       // count shown in the outgoing record
  logic                    rx_take;    // received byte is accepted
  logic                    rx_ovr;     // received byte would pass the limit
  logic                    ld_take;    // host record byte taken
  logic                    ld_bad;     // host count above the limit
  logic                    ld_end;     // last host record byte taken
  logic                    tx_idle;    // no transmit byte pending
  logic                    out_end;    // last outgoing byte

  // ==========================================================
  // decode
  // follows/valid bytes only count for the identification read
  assign rx_take = lk_rx_valid && ((st_q == asist_pkg::S_IDRX) ||
                   ((st_q == asist_pkg::S_RESP) && !lk_rx_fv));  // R6
  assign rx_ovr  = rx_take && (lcnt == asist_pkg::STR_MAX);      // R4
  assign ld_take = (st_q == asist_pkg::S_LOAD) && wr_valid;
  assign ld_bad  = ld_take && (idx == asist_pkg::CNT_POS) &&
                   (wr_byte > asist_pkg::STR_MAX);               // R17
  // the byte 2 count fixes the record length
  assign ld_end  = ld_take && ((idx == asist_pkg::CNT_POS) ?
                   (wr_byte == asist_pkg::CNT_RST) :
                   (idx == cnt_q + asist_pkg::CNT_POS));         // R9
  assign tx_idle = !lk_tx_valid_q && !tx_ph_q;
  assign ocnt    = (kind_q == asist_pkg::JOB_RD_RESP) ? resp_cnt_q : cnt_q;
  assign out_end = (st_q == asist_pkg::S_OUT) &&
                   (idx == ocnt + asist_pkg::CNT_POS);

  // ==========================================================
  // counters
  asist_cnt #(.W(8)) u_idx (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clr     (st_q == asist_pkg::S_IDLE),
    .inc     (ld_take || (st_q == asist_pkg::S_OUT)),
    .cnt_q   (idx)
  );

  asist_cnt #(.W(8)) u_lcnt (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clr     ((st_q == asist_pkg::S_IDLE) ||
              ((st_q == asist_pkg::S_SEND) && tx_idle && (lcnt == cnt_q))),
    .inc     (tx_ph_q || (rx_take && !rx_ovr)),
    .cnt_q   (lcnt)
  );

  // ==========================================================
  // stores: staging for request and identification, one kept response
  // string byte 1 lands at address 0 and is never looked into
  asist_mem #(.AW(8), .DW(8)) u_stg (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .we      ((ld_take && (idx >= asist_pkg::HDR_LEN)) ||
              ((st_q == asist_pkg::S_IDRX) && rx_take && !rx_ovr)),  // R11
    .waddr   (ld_take ? idx - asist_pkg::HDR_LEN : lcnt),
    .wdata   (ld_take ? wr_byte : lk_rx_byte),
    .raddr   ((st_q == asist_pkg::S_OUT) ? idx - asist_pkg::CNT_POS : lcnt),
    .rdata_q (stg_rd)
  );

  // a new response simply overwrites the previous one
  asist_mem #(.AW(8), .DW(8)) u_rsp (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .we      ((st_q == asist_pkg::S_RESP) && rx_take && !rx_ovr),  // R16
    .waddr   (lcnt),
    .wdata   (lk_rx_byte),
    .raddr   (idx - asist_pkg::CNT_POS),
    .rdata_q (rsp_rd)
  );

  // ==========================================================
  // job state machine
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= asist_pkg::S_IDLE;
    end else begin
      case (st_q)
        asist_pkg::S_IDLE: begin
          if (job_start) begin
            case (job_kind)
              asist_pkg::JOB_ID_READ: st_q <= asist_pkg::S_IDRX;  // R1
              asist_pkg::JOB_WR_REQ:  st_q <= asist_pkg::S_LOAD;
              asist_pkg::JOB_RD_RESP: st_q <= asist_pkg::S_OUT;   // R14
              default:                st_q <= asist_pkg::S_IDLE;
            endcase
          end
        end
        asist_pkg::S_LOAD: begin
          if (ld_bad) begin
            st_q <= asist_pkg::S_IDLE;  // R17
          end else if (ld_end) begin
            st_q <= asist_pkg::S_SEND;
          end
        end
        asist_pkg::S_SEND: begin
          if (tx_idle && (lcnt == cnt_q)) begin
            st_q <= asist_pkg::S_RESP;
          end
        end
        asist_pkg::S_RESP: begin
          if (rx_ovr || lk_rx_end) begin
            st_q <= asist_pkg::S_IDLE;
          end
        end
        asist_pkg::S_IDRX: begin
          if (rx_ovr) begin
            st_q <= asist_pkg::S_IDLE;  // R4
          end else if (lk_rx_end) begin
            st_q <= asist_pkg::S_OUT;
          end
        end
        asist_pkg::S_OUT: begin
          if (out_end) begin
            st_q <= asist_pkg::S_IDLE;
          end
        end
        default: st_q <= asist_pkg::S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // job kind and slave address, held for the whole job
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      kind_q     <= asist_pkg::JOB_ID_READ;
      lk_slave_q <= 5'h00;
    end else if ((st_q == asist_pkg::S_IDLE) && job_start) begin
      kind_q     <= asist_pkg::asist_job_t'(job_kind);
      lk_slave_q <= job_slave;
    end
  end

  // ==========================================================
  // string counts
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q      <= asist_pkg::CNT_RST;
      resp_cnt_q <= asist_pkg::CNT_RST;
    end else begin
      if (ld_take && (idx == asist_pkg::CNT_POS)) begin
        cnt_q <= wr_byte;  // R9
      end else if ((st_q == asist_pkg::S_IDRX) && lk_rx_end && !rx_ovr) begin
        cnt_q <= lcnt;  // R3
      end
      // an aborted response leaves nothing to fetch
      if ((st_q == asist_pkg::S_RESP) && rx_ovr) begin
        resp_cnt_q <= asist_pkg::CNT_RST;  // R4
      end else if ((st_q == asist_pkg::S_RESP) && lk_rx_end) begin
        resp_cnt_q <= lcnt;  // R10
      end
    end
  end

  // ==========================================================
  // link request pulses
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_start_q <= 1'b0;
      lk_id_q    <= 1'b0;
      lk_abort_q <= 1'b0;
    end else begin
      // identification starts at once, a request only once fully loaded
      lk_start_q <= ((st_q == asist_pkg::S_IDLE) && job_start &&
                     (job_kind == asist_pkg::JOB_ID_READ)) ||
                    (ld_end && !ld_bad);  // R1
      if ((st_q == asist_pkg::S_IDLE) && job_start) begin
        lk_id_q <= (job_kind == asist_pkg::JOB_ID_READ);
      end
      lk_abort_q <= rx_ovr;  // R4
    end
  end

  // ==========================================================
  // transmit: read issue, then hold the byte until the link takes it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ph_q       <= 1'b0;
      lk_tx_byte_q  <= 8'h00;
      lk_tx_valid_q <= 1'b0;
      lk_tx_last_q  <= 1'b0;
    end else begin
      tx_ph_q <= (st_q == asist_pkg::S_SEND) && tx_idle && (lcnt != cnt_q);
      if (tx_ph_q) begin
        lk_tx_byte_q  <= stg_rd;  // R9
        lk_tx_valid_q <= 1'b1;
        lk_tx_last_q  <= (lcnt + 8'h01 == cnt_q);
      end else if (lk_tx_valid_q && lk_tx_ready) begin
        lk_tx_valid_q <= 1'b0;
        lk_tx_last_q  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outgoing record: version bytes, count, then stored string
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_byte_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      rd_last_q  <= 1'b0;
    end else begin
      rd_valid_q <= (st_q == asist_pkg::S_OUT);
      rd_last_q  <= out_end;
      if (idx == 8'h00) begin
        rd_byte_q <= asist_pkg::VER_HI;  // R7
      end else if (idx == 8'h01) begin
        rd_byte_q <= asist_pkg::VER_LO;  // R7
      end else if (idx == asist_pkg::CNT_POS) begin
        rd_byte_q <= ocnt;  // R15
      end else begin
        rd_byte_q <= (kind_q == asist_pkg::JOB_RD_RESP) ? rsp_rd : stg_rd;
      end
    end
  end

  // ==========================================================
  // job status
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q     <= 1'b0;
      job_done_q <= 1'b0;
      job_err_q  <= 1'b0;
    end else begin
      busy_q     <= (st_q != asist_pkg::S_IDLE);
      job_done_q <= ld_bad || rx_ovr || out_end ||
                    ((st_q == asist_pkg::S_RESP) && lk_rx_end) ||
                    ((st_q == asist_pkg::S_IDLE) && job_start && (job_kind == 2'h3));
      job_err_q  <= ld_bad || rx_ovr ||
                    ((st_q == asist_pkg::S_IDLE) && job_start && (job_kind == 2'h3));
    end
  end

  // ==========================================================
  // cyclic exchange hold; digital bits are never held
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ana_hold_q   <= 1'b0;
      hold_slave_q <= 5'h00;
    end else begin
      ana_hold_q   <= (st_q == asist_pkg::S_SEND) || (st_q == asist_pkg::S_RESP) ||
                      (st_q == asist_pkg::S_IDRX);  // R5 R12
      hold_slave_q <= lk_slave_q;
    end
  end

  // ==========================================================
  // checks
  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      (st_q == asist_pkg::S_IDRX) |=> ana_hold_q;
  endproperty
  a_hold: assert property (p_hold) else $error("hold missing in transfer"); // R5

  property p_ovr;
    @(posedge sys_clk) disable iff (!reset_n)
      rx_ovr |=> job_err_q && job_done_q && lk_abort_q && (st_q == asist_pkg::S_IDLE);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overlength not aborted"); // R4

  property p_cnt;
    @(posedge sys_clk) disable iff (!reset_n)
      (st_q == asist_pkg::S_OUT) && (idx == asist_pkg::CNT_POS) |=>
        rd_valid_q && (rd_byte_q <= asist_pkg::STR_MAX);
  endproperty
  a_cnt: assert property (p_cnt) else $error("record count too large"); // R2

  property p_ver;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(rd_valid_q) |-> (rd_byte_q == asist_pkg::VER_HI) ##1
        (rd_valid_q && rd_byte_q == asist_pkg::VER_LO);
  endproperty
  a_ver: assert property (p_ver) else $error("version bytes wrong"); // R7

  property p_rej;
    @(posedge sys_clk) disable iff (!reset_n)
      ld_bad |=> job_err_q && !lk_start_q ##1 !lk_tx_valid_q;
  endproperty
  a_rej: assert property (p_rej) else $error("bad count not rejected"); // R17

  property p_fv;
    @(posedge sys_clk) disable iff (!reset_n)
      (st_q == asist_pkg::S_RESP) && lk_rx_valid && lk_rx_fv |=> $stable(lcnt);
  endproperty
  a_fv: assert property (p_fv) else $error("flag byte kept in response"); // R6

  property p_resp;
    @(posedge sys_clk) disable iff (!reset_n)
      (st_q == asist_pkg::S_RESP) && lk_rx_end && !rx_ovr |=>
        (resp_cnt_q == $past(lcnt)) && job_done_q && !job_err_q;
  endproperty
  a_resp: assert property (p_resp) else $error("response not kept"); // R10

  property p_tx;
    @(posedge sys_clk) disable iff (!reset_n)
      lk_tx_valid_q && !lk_tx_ready |=> lk_tx_valid_q && $stable(lk_tx_byte_q);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit byte dropped"); // R9

  property p_last;
    @(posedge sys_clk) disable iff (!reset_n)
      rd_last_q |-> rd_valid_q ##1 !rd_valid_q;
  endproperty
  a_last: assert property (p_last) else $error("record runs past its end"); // R15

endmodule // asist_engine

// ===== sim/asist_slave_model.sv
// far-side slave model: takes request bytes and answers with a string
`timescale 1ns/1ps
module asist_slave_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // link request from the engine
  input  wire logic       lk_start_q,
  input  wire logic       lk_id_q,
  input  wire logic       lk_abort_q,
  input  wire logic [7:0] lk_tx_byte_q,
  input  wire logic       lk_tx_valid_q,
  input  wire logic       lk_tx_last_q,
  output logic            lk_tx_ready,
  // answer bytes towards the engine
  output logic [7:0]      lk_rx_byte,
  output logic            lk_rx_valid,
  output logic            lk_rx_fv,
  output logic            lk_rx_end,
  // scenario settings
  input  wire logic [7:0] tx_n,
  input  wire logic [8:0] rsp_len,
  input  wire logic       fv_extra,
  input  wire logic       slow,
  // what arrived
  output logic [7:0]      tx_cnt,
  output logic [7:0]      tx_hash
);
  logic [1:0] st_q;   // 0 idle, 1 take, 2 answer, 3 end pulse
  logic [8:0] idx_q;  // answer bytes sent
  logic       gap_q;  // pacing toggle for slow mode

  // ==========================================================
  // link process; idle data toggles so a stale byte never looks valid
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q        <= 2'h0;
      idx_q       <= 9'h000;
      gap_q       <= 1'b0;
      lk_tx_ready <= 1'b0;
      lk_rx_byte  <= 8'h00;
      lk_rx_valid <= 1'b0;
      lk_rx_fv    <= 1'b0;
      lk_rx_end   <= 1'b0;
      tx_cnt      <= 8'h00;
      tx_hash     <= 8'h00;
    end else begin
      lk_rx_valid <= 1'b0;
      lk_rx_fv    <= 1'b0;
      lk_rx_end   <= 1'b0;
      lk_rx_byte  <= ~lk_rx_byte;
      gap_q       <= ~gap_q;
      if (lk_abort_q) begin
        st_q        <= 2'h0;
        lk_tx_ready <= 1'b0;
      end else case (st_q)
        2'h0: if (lk_start_q) begin
          tx_cnt  <= 8'h00;
          tx_hash <= 8'h00;
          idx_q   <= 9'h000;
          st_q    <= (lk_id_q || tx_n == 8'h00) ? 2'h2 : 2'h1;
        end
        2'h1: if (lk_tx_ready) begin
          // byte taken at the handshake edge, order kept in the hash
          lk_tx_ready <= 1'b0;
          tx_cnt      <= tx_cnt + 8'h01;
          tx_hash     <= {tx_hash[6:0], tx_hash[7]} ^ lk_tx_byte_q;
          if (lk_tx_last_q) begin
            st_q <= 2'h2;
          end
        end else if (lk_tx_valid_q && (!slow || gap_q)) begin
          lk_tx_ready <= 1'b1;
        end
        2'h2: if (!slow || gap_q) begin
          if (idx_q < rsp_len + {8'h00, fv_extra}) begin
            lk_rx_valid <= 1'b1;
            lk_rx_fv    <= (idx_q >= rsp_len);
            lk_rx_byte  <= (idx_q < rsp_len) ? 8'h40 + idx_q[7:0] : 8'hee;
            idx_q       <= idx_q + 9'h001;
          end else begin
            st_q <= 2'h3;
          end
        end
        default: begin
          // end marker in a cycle of its own
          lk_rx_end <= 1'b1;
          st_q      <= 2'h0;
        end
      endcase
    end
  end
endmodule // asist_slave_model

// ===== sim/asist_engine_test.sv
// self-checking bench of the string transfer job engine
`timescale 1ns/1ps
module asist_engine_test;
  // ==========================================================
  // job row: kind, count, answer length, extra fv byte, slow, error
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] n;
    logic [8:0] rsp;
    logic       fv;
    logic       slow;
    logic       err;
  } asist_row_t;

  logic sys_clk = 1'b0, reset_n = 1'b0, job_start = 1'b0, wr_valid = 1'b0;
  logic [1:0] job_kind = 2'h0;
  logic [4:0] job_slave = 5'h00, cur_slave = 5'h00, slv_seen;
  logic [7:0] wr_byte = 8'h00, tx_n = 8'h00, rd_byte_q, lk_tx_byte_q, lk_rx_byte;
  logic [7:0] tx_cnt, tx_hash;
  logic [8:0] rsp_len = 9'h000;
  logic fv_extra = 1'b0, slow = 1'b0, id_seen, err_seen, rec_last;
  logic busy_q, job_done_q, job_err_q, rd_valid_q, rd_last_q, lk_start_q, lk_id_q;
  logic lk_abort_q, lk_tx_valid_q, lk_tx_last_q, lk_tx_ready, lk_rx_valid, lk_rx_fv;
  logic lk_rx_end, ana_hold_q;
  logic [4:0] lk_slave_q, hold_slave_q;
  logic [7:0] rec[$];   // record bytes seen
  int fails = 0, checks = 0, starts, holds, bad_hold, dones, kept = 0;

  always #20 sys_clk = ~sys_clk;

  asist_engine dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .job_start(job_start),
    .job_kind(job_kind), .job_slave(job_slave), .wr_byte(wr_byte), .wr_valid(wr_valid),
    .busy_q(busy_q), .job_done_q(job_done_q), .job_err_q(job_err_q),
    .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q), .rd_last_q(rd_last_q),
    .lk_start_q(lk_start_q), .lk_id_q(lk_id_q), .lk_slave_q(lk_slave_q),
    .lk_abort_q(lk_abort_q), .lk_tx_byte_q(lk_tx_byte_q), .lk_tx_valid_q(lk_tx_valid_q),
    .lk_tx_last_q(lk_tx_last_q), .lk_tx_ready(lk_tx_ready), .lk_rx_byte(lk_rx_byte),
    .lk_rx_valid(lk_rx_valid), .lk_rx_fv(lk_rx_fv), .lk_rx_end(lk_rx_end),
    .ana_hold_q(ana_hold_q), .hold_slave_q(hold_slave_q));

  asist_slave_model slave_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .lk_start_q(lk_start_q), .lk_id_q(lk_id_q), .lk_abort_q(lk_abort_q),
    .lk_tx_byte_q(lk_tx_byte_q), .lk_tx_valid_q(lk_tx_valid_q),
    .lk_tx_last_q(lk_tx_last_q), .lk_tx_ready(lk_tx_ready), .lk_rx_byte(lk_rx_byte),
    .lk_rx_valid(lk_rx_valid), .lk_rx_fv(lk_rx_fv), .lk_rx_end(lk_rx_end),
    .tx_n(tx_n), .rsp_len(rsp_len), .fv_extra(fv_extra), .slow(slow),
    .tx_cnt(tx_cnt), .tx_hash(tx_hash));

  // ==========================================================
  // monitor at the falling edge, where registered outputs have settled
  always @(negedge sys_clk) begin
    if (rd_valid_q === 1'b1) begin
      rec.push_back(rd_byte_q);
      rec_last = rd_last_q;
    end
    if (lk_start_q === 1'b1) begin
      starts++;
      id_seen  = lk_id_q;
      slv_seen = lk_slave_q;
    end
    if (ana_hold_q === 1'b1) begin
      holds++;
      if (hold_slave_q !== cur_slave) bad_hold++;
    end
    if (job_done_q === 1'b1) begin
      dones++;
      err_seen = job_err_q;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic clear_seen();
    rec.delete();
    starts = 0;
    holds = 0;
    bad_hold = 0;
    dones = 0;
    rec_last = 1'b0;
  endtask

  // ==========================================================
  // one job: request, send record if a write, wait, compare
  task automatic run_row(input asist_row_t r);
    int k, exp_n;
    logic go;
    logic [7:0] e_hash, e_b;
    clear_seen();
    go = (r.kind == 2'h0) || (r.kind == 2'h1 && r.n <= 8'hdc);
    e_hash = 8'h00;
    @(posedge sys_clk);
    tx_n <= r.n;
    rsp_len <= r.rsp;
    fv_extra <= r.fv;
    slow <= r.slow;
    job_kind <= r.kind;
    job_slave <= cur_slave;
    job_start <= 1'b1;
    @(posedge sys_clk);
    job_start <= 1'b0;
    // an oversize count gets only the header: the rest must not follow
    if (r.kind == 2'h1) for (k = 0; k < ((r.n > 8'hdc) ? 3 : 3 + int'(r.n)); k++) begin
      e_b = (k < 2) ? 8'h00 : (k == 2) ? r.n : 8'h10 + k[7:0];
      if (k > 2) e_hash = {e_hash[6:0], e_hash[7]} ^ e_b;
      wr_valid <= 1'b1;
      wr_byte <= e_b;
      @(posedge sys_clk);
    end
    wr_valid <= 1'b0;
    for (k = 0; k < 4000 && dones == 0; k++) @(negedge sys_clk);
    @(negedge sys_clk);
    exp_n = r.err ? 0 : (r.kind == 2'h0) ? 3 + int'(r.rsp) + int'(r.fv) :
            (r.kind == 2'h2) ? 3 + kept : 0;
    chk(16'(dones), 16'h0001, "done pulses");
    chk(16'(err_seen), 16'(r.err), "error flag");
    chk(16'(rec.size()), 16'(exp_n), "record length");
    chk(16'(ana_hold_q), 16'h0000, "hold after job");
    if (exp_n > 0) begin
      chk(16'({rec[0], rec[1]}), 16'h0000, "version bytes");
      chk(16'(rec[2]), 16'(exp_n - 3), "string count");
      chk(16'(rec_last), 16'h0001, "last marker");
    end
    for (k = 3; k < exp_n; k++) begin
      e_b = (r.kind == 2'h0 && r.fv && k == exp_n - 1) ? 8'hee : 8'h40 + 8'(k - 3);
      chk(16'(rec[k]), 16'(e_b), "string byte");
    end
    chk(16'(starts), 16'(go), "link starts");
    if (go) begin
      chk(16'({id_seen, slv_seen}), 16'({r.kind == 2'h0, cur_slave}), "link target");
      chk(16'(holds > 0), 16'h0001, "hold seen");
      chk(16'(bad_hold), 16'h0000, "hold address");
    end
    if (r.kind == 2'h1 && go) begin
      chk(16'(tx_cnt), 16'(r.n), "bytes forwarded");
      chk(16'(tx_hash), 16'(e_hash), "forwarded order");
      kept = r.err ? 0 : int'(r.rsp);
    end
  endtask

  localparam int NR = 13;
  asist_row_t rows [NR] = '{
    '{2'h0, 8'h00, 9'h005, 1'b1, 1'b0, 1'b0}, '{2'h2, 8'h00, 9'h000, 1'b0, 1'b0, 1'b0},
    '{2'h1, 8'h03, 9'h004, 1'b1, 1'b0, 1'b0}, '{2'h1, 8'h00, 9'h007, 1'b0, 1'b1, 1'b0},
    '{2'h2, 8'h00, 9'h000, 1'b0, 1'b0, 1'b0}, '{2'h0, 8'h00, 9'h0dc, 1'b0, 1'b1, 1'b0},
    '{2'h0, 8'h00, 9'h0dd, 1'b0, 1'b0, 1'b1}, '{2'h1, 8'hdc, 9'h001, 1'b0, 1'b0, 1'b0},
    '{2'h1, 8'hdd, 9'h000, 1'b0, 1'b0, 1'b1}, '{2'h2, 8'h00, 9'h000, 1'b0, 1'b0, 1'b0},
    '{2'h1, 8'h02, 9'h0dd, 1'b0, 1'b0, 1'b1}, '{2'h2, 8'h00, 9'h000, 1'b0, 1'b0, 1'b0},
    '{2'h3, 8'h00, 9'h000, 1'b0, 1'b0, 1'b1}};

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk(16'({busy_q, job_done_q, lk_start_q, ana_hold_q, rd_valid_q, lk_tx_valid_q}),
        16'h0000, "outputs after reset");
    $display("test reset done");
    for (int i = 0; i < NR; i++) begin
      cur_slave = 5'h11 + 5'(i);
      run_row(rows[i]);
      $display("test row %0d done", i);
    end
    // a second request while busy is ignored, the running job ends cleanly
    clear_seen();
    @(posedge sys_clk);
    rsp_len <= 9'h003;
    slow <= 1'b1;
    job_kind <= 2'h0;
    job_start <= 1'b1;
    @(posedge sys_clk);
    job_start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(16'(busy_q), 16'h0001, "busy during job");
    @(posedge sys_clk);
    job_kind <= 2'h3;
    job_start <= 1'b1;
    @(posedge sys_clk);
    job_start <= 1'b0;
    for (int k = 0; k < 4000 && dones == 0; k++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    chk(16'({dones[3:0], err_seen}), 16'h0002, "start while busy");
    chk(16'(rec.size()), 16'h0006, "record while busy");
    $display("test busy start done");
    stop_test();
  end

  // watchdog, well past the expected run length
  initial begin
    #(40 * 30000);
    fails++;
    stop_test();
  end
endmodule // asist_engine_test
